// ==== hdl/gsm_pkg.sv ====
// Functional notes
// - Off mode: no automatic bias, no close action
// - Off when switch not auto, cmd off, closed
// - Off mode: manual raise/lower move both biases
// - Run needs auto; manual switches ignored
// - Run: hold biases during close pulse
// - Run: close pulse ends on time or aux
// - Check: match only, never close, needs auto
// - Permissive: close when in limits, manual allowed
// - No voltage matching: no automatic voltage bias
// - Dead bus below range threshold 27/40/80 V
// - Dead close: bus aux open, enabled, dead
// - Speed correction from PI, separate gains
// - Slip type: regulate to slip within window
// - Close only inside phase match window or on a dead bus
// - Phase type: slip limits speed difference
// - Phase type: correct only outside window
// - Phase error from generator and bus phase A
// - Voltage bias into window, then hold steady
// - Match in check/run; permissive only checks
// - Voltage bias limit without match raises alarm
// - Voltage matching withholds close outside window
// - Close ahead of zero from slip and delay
// - Most recent mode command source wins
// - Sync type phase, slip or off
package gsm_pkg;

  typedef enum logic [1:0] {
    GSM_OFF   = 2'b00,
    GSM_CHECK = 2'b01,
    GSM_PERM  = 2'b10,
    GSM_RUN   = 2'b11
  } gsm_mode_t;

  typedef enum logic [1:0] {
    GSM_ST_OFF   = 2'b00,
    GSM_ST_PHASE = 2'b01,
    GSM_ST_SLIP  = 2'b10
  } gsm_stype_t;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [4:0]  GSM_REG_CTRL = 5'h00;
  localparam logic [4:0]  GSM_REG_GAIN = 5'h04;
  localparam logic [4:0]  GSM_REG_SLIP = 5'h08;
  localparam logic [4:0]  GSM_REG_WIN  = 5'h0c;
  localparam logic [4:0]  GSM_REG_TIME = 5'h10;
  localparam logic [4:0]  GSM_REG_STAT = 5'h14;
  localparam int          GSM_CTRL_MODE  = 0;
  localparam int          GSM_CTRL_STYPE = 2;
  localparam int          GSM_CTRL_VM    = 4;
  localparam int          GSM_CTRL_DB    = 5;
  localparam int          GSM_CTRL_RNG   = 6;
  localparam logic [31:0] GSM_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] GSM_GAIN_RST = 32'h0000_0404;
  localparam logic [31:0] GSM_SLIP_RST = 32'h0020_0010;
  localparam logic [31:0] GSM_WIN_RST  = 32'h0020_0100;
  localparam logic [31:0] GSM_TIME_RST = 32'h0010_0020;

  // ==========================================================
  // Pin vector positions
  localparam int GSM_PIN_AUTO = 0;
  localparam int GSM_PIN_SUP  = 1;
  localparam int GSM_PIN_SDN  = 2;
  localparam int GSM_PIN_VUP  = 3;
  localparam int GSM_PIN_VDN  = 4;
  localparam int GSM_PIN_GAUX = 5;
  localparam int GSM_PIN_BAUX = 6;
  localparam int GSM_PINS     = 7;

  // ==========================================================
  // Dead bus thresholds in volts L-N per range
  localparam logic [15:0] GSM_DEAD_LO  = 16'h001b;
  localparam logic [15:0] GSM_DEAD_MID = 16'h0028;
  localparam logic [15:0] GSM_DEAD_HI  = 16'h0050;

  // ==========================================================
  // Timing and scaling
  localparam int                 GSM_CLK_MHZ     = 200;
  localparam int                 GSM_CTRL_NS     = 1000;
  localparam int                 GSM_CTRL_CYC    = GSM_CTRL_NS * GSM_CLK_MHZ / 1000;
  localparam int                 GSM_LEAD_SHIFT  = 8;
  localparam int                 GSM_P_SHIFT     = 4;
  localparam int                 GSM_I_SHIFT     = 8;
  localparam logic [15:0]        GSM_MAN_STEP    = 16'h0010;
  localparam logic [15:0]        GSM_VOLT_STEP   = 16'h0004;
  localparam logic signed [15:0] GSM_BIAS_MAX    = 16'sh7f00;
  localparam logic signed [15:0] GSM_BIAS_MIN    = -16'sh7f00;

  function automatic logic signed [15:0] gsm_sat16(input logic signed [25:0] v);
    if (v > 26'(GSM_BIAS_MAX)) begin
      return GSM_BIAS_MAX;
    end else if (v < 26'(GSM_BIAS_MIN)) begin
      return GSM_BIAS_MIN;
    end
    return v[15:0];
  endfunction

  function automatic logic [17:0] gsm_abs(input logic signed [17:0] v);
    return v[17] ? 18'(-v) : 18'(v);
  endfunction

  // Manual or stepwise bias move, saturating at the limits
  function automatic logic signed [15:0] gsm_nudge(input logic signed [15:0] b,
                                                   input logic up, input logic dn,
                                                   input logic [15:0] st);
    logic signed [25:0] s;
    s = 26'(b);
    if (up && !dn) begin
      s = s + 26'(st);
    end else if (dn && !up) begin
      s = s - 26'(st);
    end
    return gsm_sat16(s);
  endfunction

endpackage

// ==== hdl/gsm_pi_if.sv ====
`timescale 1ns/100ps
// ============================================================
// Speed loop carrier between the mode logic and the PI stage
interface gsm_pi_if;
  import gsm_pkg::*;
  logic signed [15:0] err;
  logic        [7:0]  kp;
  logic        [7:0]  ki;
  logic               tick;
  logic               hold;
  logic               clr;
  logic signed [15:0] bias;
  modport ctl (output err, kp, ki, tick, hold, clr, input bias);
  modport pi  (input err, kp, ki, tick, hold, clr, output bias);
endinterface

// ==== hdl/gsm_pi.sv ====
`timescale 1ns/100ps
// ============================================================
// PI speed controller, updated once per control tick
module gsm_pi (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Loop
  gsm_pi_if.pi     pif
);
  import gsm_pkg::*;

  typedef struct packed {
    logic signed [23:0] integ;
    logic signed [15:0] bias;
  } gsm_pi_st_t;

  gsm_pi_st_t s_q, s_d;
  logic signed [25:0] ki_term;
  logic signed [25:0] kp_term;
  logic signed [25:0] isum;

  assign ki_term = 26'(pif.err * $signed({1'b0, pif.ki}));
  assign kp_term = 26'(pif.err * $signed({1'b0, pif.kp}));
  assign isum    = 26'(s_q.integ) + ki_term;

  always_comb begin
    s_d = s_q;
    if (pif.clr) begin
      s_d = '0;
    end else if (pif.tick && !pif.hold) begin
      // Integrator clamps instead of wrapping so a long error cannot flip sign
      if (isum > 26'sh07f_ffff) begin
        s_d.integ = 24'sh7f_ffff;
      end else if (isum < -26'sh080_0000) begin
        s_d.integ = -24'sh80_0000;
      end else begin
        s_d.integ = isum[23:0];
      end
      s_d.bias = gsm_sat16((kp_term >>> GSM_P_SHIFT) +
                           (26'(s_q.integ) >>> GSM_I_SHIFT));
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pif.bias = s_q.bias;

endmodule // gsm_pi

// ==== hdl/gsm_top.sv ====
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// ============================================================
// Generator synchronizer: mode, sync-check and bias logic
module gsm_top #(
  parameter int CTRL_CYC = gsm_pkg::GSM_CTRL_CYC
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [3:0]         avs_byteenable_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Panel mode command
  input  wire logic               panel_mode_wr_i,
  input  wire gsm_pkg::gsm_mode_t panel_mode_i,
  // Switches and breaker contacts (asynchronous pins)
  input  wire logic               auto_sw_i,
  input  wire logic               spd_raise_i,
  input  wire logic               spd_lower_i,
  input  wire logic               volt_raise_i,
  input  wire logic               volt_lower_i,
  input  wire logic               gen_aux_i,
  input  wire logic               bus_aux_i,
  // Measurements
  input  wire logic signed [15:0] gen_phase_i,
  input  wire logic signed [15:0] bus_phase_i,
  input  wire logic signed [15:0] slip_i,
  input  wire logic [15:0]        gen_volt_i,
  input  wire logic [15:0]        bus_volt_i,
  // Outputs
  output logic signed [15:0]      spd_bias_o,
  output logic signed [15:0]      volt_bias_o,
  output logic                    close_o,
  output logic                    dead_bus_o,
  output logic                    volt_alarm_o,
  output gsm_pkg::gsm_mode_t      mode_o
);
  import gsm_pkg::*;

  if (CTRL_CYC < 2 || CTRL_CYC > 65535) begin : g_chk
    $error("gsm_top: CTRL_CYC out of range");
  end

  localparam logic [15:0] DIV_TOP = 16'(CTRL_CYC - 1);

  typedef struct packed {
    logic [GSM_PINS-1:0] pin_s1;
    logic [GSM_PINS-1:0] pin_s2;
    logic [GSM_PINS-1:0] smp;
    logic [15:0]         div;
    logic                waitreq;
    logic [31:0]         rdata;
    gsm_mode_t           cmd;
    logic [31:0]         ctrl;
    logic [31:0]         gain;
    logic [31:0]         slip;
    logic [31:0]         win;
    logic [31:0]         tim;
    gsm_mode_t           mode;
    logic                lock;
    logic                close;
    logic [15:0]         ccnt;
    logic signed [15:0]  sbias;
    logic signed [15:0]  vbias;
    logic                dead;
    logic                valarm;
  } gsm_st_t;

  gsm_st_t s_q, s_d;
  gsm_pi_if pif ();

  gsm_pi u_pi (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .pif       (pif)
  );

  // ==========================================================
  // Configuration fields
  gsm_stype_t         stype;
  logic               vm_en;
  logic               db_en;
  logic [1:0]         rng;
  logic [15:0]        slipf;
  logic [15:0]        slipw;
  logic [15:0]        phw;
  logic [15:0]        vwin;
  logic [15:0]        cpulse;
  logic [15:0]        bdelay;

  assign stype  = gsm_stype_t'(s_q.ctrl[GSM_CTRL_STYPE +: 2]);
  assign vm_en  = s_q.ctrl[GSM_CTRL_VM];
  assign db_en  = s_q.ctrl[GSM_CTRL_DB];
  assign rng    = s_q.ctrl[GSM_CTRL_RNG +: 2];
  assign slipf  = s_q.slip[15:0];
  assign slipw  = s_q.slip[31:16];
  assign phw    = s_q.win[15:0];
  assign vwin   = s_q.win[31:16];
  assign cpulse = s_q.tim[15:0];
  assign bdelay = s_q.tim[31:16];

  // ==========================================================
  // Sync-check arithmetic
  logic [GSM_PINS-1:0] pins;
  logic signed [17:0]  ph;
  logic signed [32:0]  lead_full;
  logic signed [17:0]  pred;
  logic signed [17:0]  vdiff;
  logic signed [17:0]  sdev;
  logic                phase_in;
  logic                pred_in;
  logic                freq_ok;
  logic                volt_in;
  logic                v_ok;
  logic [15:0]         dead_thr;
  logic                dead_now;
  logic                dead_ok;
  logic                sync_ok;
  logic                tick;

  assign pins = {bus_aux_i, gen_aux_i, volt_lower_i, volt_raise_i,
                 spd_lower_i, spd_raise_i, auto_sw_i};
  assign tick = (s_q.div == '0);

  assign ph        = 18'(gen_phase_i) - 18'(bus_phase_i);
  assign phase_in  = gsm_abs(ph) <= {2'b00, phw};
  assign lead_full = slip_i * $signed({1'b0, bdelay});
  assign pred      = ph + lead_full[GSM_LEAD_SHIFT +: 18];
  // Prediction is also bounded by the window, so a large lead cannot widen it
  assign pred_in   = gsm_abs(pred) <= {2'b00, phw};
  assign sdev      = 18'(slip_i) - 18'($signed({1'b0, slipf}));
  assign freq_ok   = (stype == GSM_ST_SLIP) ? (gsm_abs(sdev) <= {2'b00, slipw})
                                            : (gsm_abs(18'(slip_i)) <= {2'b00, slipf});
  assign vdiff     = $signed({2'b00, gen_volt_i}) - $signed({2'b00, bus_volt_i});
  assign volt_in   = gsm_abs(vdiff) <= {2'b00, vwin};
  assign v_ok      = !vm_en || volt_in;

  always_comb begin
    unique case (rng)
      2'b00:   dead_thr = GSM_DEAD_LO;
      2'b01:   dead_thr = GSM_DEAD_MID;
      default: dead_thr = GSM_DEAD_HI;
    endcase
  end

  assign dead_now = bus_volt_i < dead_thr;
  assign dead_ok  = !s_q.pin_s2[GSM_PIN_BAUX] && db_en && dead_now;
  assign sync_ok  = dead_ok || (phase_in && pred_in && freq_ok && v_ok);

  // ==========================================================
  // Speed loop drive
  logic signed [17:0] perr;
  assign perr = -ph;
  always_comb begin
    pif.err = '0;
    if (stype == GSM_ST_SLIP) begin
      pif.err = gsm_sat16(26'(-sdev));
    end else if (!phase_in) begin
      pif.err = gsm_sat16(26'(perr));
    end
  end
  assign pif.kp   = s_q.gain[7:0];
  assign pif.ki   = s_q.gain[15:8];
  assign pif.tick = tick;
  assign pif.hold = s_q.close;
  assign pif.clr  = !(s_q.mode inside {GSM_CHECK, GSM_RUN});

  // ==========================================================
  // Register bus helpers
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic        bus_hit;
  logic [31:0] rd_mux;
  logic [31:0] stat;

  assign bus_hit = (avs_read_i || avs_write_i) && s_q.waitreq;
  assign stat    = {16'h0000, 9'h000, phase_in, s_q.lock, s_q.valarm,
                    s_q.dead, s_q.close, s_q.mode};

  always_comb begin
    unique case (avs_address_i)
      GSM_REG_CTRL: rd_mux = s_q.ctrl;
      GSM_REG_GAIN: rd_mux = s_q.gain;
      GSM_REG_SLIP: rd_mux = s_q.slip;
      GSM_REG_WIN:  rd_mux = s_q.win;
      GSM_REG_TIME: rd_mux = s_q.tim;
      GSM_REG_STAT: rd_mux = stat;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  logic      cmd_new;
  gsm_mode_t mode_n;
  logic      auto_n;
  logic      gaux_n;
  logic      end_close;

  always_comb begin
    s_d       = s_q;
    cmd_new   = 1'b0;
    mode_n    = s_q.mode;
    auto_n    = s_q.pin_s2[GSM_PIN_AUTO];
    gaux_n    = s_q.pin_s2[GSM_PIN_GAUX];
    end_close = 1'b0;
    s_d.pin_s1  = pins;
    s_d.pin_s2  = s_q.pin_s1;
    s_d.div     = tick ? DIV_TOP : 16'(s_q.div - 16'h0001);
    s_d.waitreq = !bus_hit;
    if (bus_hit && avs_read_i) begin
      s_d.rdata = rd_mux;
    end
    // Panel goes first so a bus write in the same cycle counts as later
    if (panel_mode_wr_i) begin
      s_d.cmd = panel_mode_i;
      cmd_new = 1'b1;
    end
    if (bus_hit && avs_write_i) begin
      unique case (avs_address_i)
        GSM_REG_CTRL: begin
          s_d.ctrl = be_merge(s_q.ctrl, avs_writedata_i, avs_byteenable_i);
          if (avs_byteenable_i[0]) begin
            s_d.cmd = gsm_mode_t'(avs_writedata_i[GSM_CTRL_MODE +: 2]);
            cmd_new = 1'b1;
          end
        end
        GSM_REG_GAIN: s_d.gain = be_merge(s_q.gain, avs_writedata_i, avs_byteenable_i);
        GSM_REG_SLIP: s_d.slip = be_merge(s_q.slip, avs_writedata_i, avs_byteenable_i);
        GSM_REG_WIN:  s_d.win  = be_merge(s_q.win, avs_writedata_i, avs_byteenable_i);
        GSM_REG_TIME: s_d.tim  = be_merge(s_q.tim, avs_writedata_i, avs_byteenable_i);
        default: ;
      endcase
    end
    s_d.ctrl[GSM_CTRL_MODE +: 2] = s_d.cmd;
    // A lockout after a successful close clears only on a new command or auto loss
    if (cmd_new || !auto_n) begin
      s_d.lock = 1'b0;
    end
    if (tick) begin
      s_d.smp  = s_q.pin_s2;
      s_d.dead = dead_now;
      if (!auto_n || s_q.cmd == GSM_OFF || stype == GSM_ST_OFF ||
          stype == 2'b11 || s_d.lock) begin
        mode_n = GSM_OFF;
      end else begin
        mode_n = s_q.cmd;
      end
      // Close pulse countdown and self switch-off
      if (s_q.close) begin
        end_close = (s_q.ccnt <= 16'h0001) || gaux_n;
        s_d.ccnt  = 16'(s_q.ccnt - 16'h0001);
        if (end_close) begin
          s_d.close = 1'b0;
          if (s_q.mode == GSM_RUN || gaux_n) begin
            s_d.lock = 1'b1;
            mode_n   = GSM_OFF;
          end
        end
      end else if ((mode_n == GSM_PERM || mode_n == GSM_RUN) && sync_ok && !gaux_n &&
                   cpulse != 16'h0000) begin
        s_d.close = 1'b1;
        s_d.ccnt  = cpulse;
      end
      // Speed bias
      if (mode_n == GSM_OFF || mode_n == GSM_PERM) begin
        s_d.sbias = gsm_nudge(s_q.sbias, s_q.pin_s2[GSM_PIN_SUP],
                              s_q.pin_s2[GSM_PIN_SDN], GSM_MAN_STEP);
      end
      // Voltage bias: manual in off and permissive, stepwise toward window in check/run when matching is on
      if (mode_n == GSM_OFF || mode_n == GSM_PERM) begin
        s_d.vbias  = gsm_nudge(s_q.vbias, s_q.pin_s2[GSM_PIN_VUP],
                               s_q.pin_s2[GSM_PIN_VDN], GSM_VOLT_STEP);
        s_d.valarm = 1'b0;
      end else if (vm_en && !s_q.close) begin
        if (!volt_in) begin
          s_d.vbias = gsm_nudge(s_q.vbias, vdiff < 0, vdiff > 0, GSM_VOLT_STEP);
        end
        s_d.valarm = !volt_in && (s_q.vbias == GSM_BIAS_MAX ||
                                  s_q.vbias == GSM_BIAS_MIN);
      end
    end
    if (mode_n != GSM_PERM && mode_n != GSM_RUN) begin
      s_d.close = 1'b0;
    end
    if ((mode_n == GSM_CHECK || mode_n == GSM_RUN) && !s_q.close && !s_d.close) begin
      s_d.sbias = pif.bias;
    end
    s_d.mode = mode_n;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q         <= '0;
      s_q.waitreq <= 1'b1;
      s_q.ctrl    <= GSM_CTRL_RST;
      s_q.gain    <= GSM_GAIN_RST;
      s_q.slip    <= GSM_SLIP_RST;
      s_q.win     <= GSM_WIN_RST;
      s_q.tim     <= GSM_TIME_RST;
      s_q.cmd     <= GSM_OFF;
      s_q.mode    <= GSM_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = s_q.waitreq;
  assign spd_bias_o        = s_q.sbias;
  assign volt_bias_o       = s_q.vbias;
  assign close_o           = s_q.close;
  assign dead_bus_o        = s_q.dead;
  assign volt_alarm_o      = s_q.valarm;
  assign mode_o            = s_q.mode;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_off_no_close: assert property (s_q.mode == GSM_OFF |-> !s_q.close)
    else $error("close active in off mode");
  a_check_no_close: assert property (s_q.mode == GSM_CHECK |-> !s_q.close)
    else $error("close active in check mode");
  a_auto_needed: assert property (s_q.mode != GSM_OFF |-> s_q.smp[GSM_PIN_AUTO])
    else $error("automatic mode without auto switch");
  a_close_window: assert property ($rose(s_q.close) |-> $past(phase_in || dead_ok))
    else $error("close started outside phase window");
  a_run_bias_hold: assert property (s_q.close && $past(s_q.close) &&
                                    s_q.mode == GSM_RUN |-> $stable(s_q.sbias))
    else $error("speed bias moved during close pulse");
  a_run_close_off: assert property ($fell(s_q.close) && $past(s_q.mode) == GSM_RUN
                                    |-> s_q.mode == GSM_OFF)
    else $error("run mode did not switch off after close");
  a_vm_off_hold: assert property ((s_q.mode inside {GSM_CHECK, GSM_RUN}) && !vm_en &&
                                  $past(s_q.mode) == s_q.mode |-> $stable(s_q.vbias))
    else $error("voltage bias moved without voltage matching");
  a_manual_speed: assert property ($changed(s_q.sbias) && s_q.mode == GSM_OFF |->
                                   s_q.smp[GSM_PIN_SUP] || s_q.smp[GSM_PIN_SDN])
    else $error("off mode speed bias moved without switch");
  a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && s_q.waitreq |=>
                                   !s_q.waitreq)
    else $error("waitrequest not released after one cycle");

  c_run_close: cover property (s_q.mode == GSM_RUN ##1 $rose(s_q.close));
  c_dead_close: cover property ($rose(s_q.close) && $past(dead_ok));
  c_perm_close: cover property (s_q.mode == GSM_PERM && $rose(s_q.close));
  c_volt_alarm: cover property ($rose(s_q.valarm));

endmodule // gsm_top

// ==== verif/gsm_plant.sv ====
`timescale 1ns/100ps
// ============================================================
// Far side: breaker, speed control and regulator as a crude plant
module gsm_plant (
  // Clock
  input  wire logic               clock_i,
  // From the synchronizer
  input  wire logic               close_i,
  input  wire logic signed [15:0] spd_bias_i,
  input  wire logic signed [15:0] volt_bias_i,
  // Scenario control
  input  wire logic               stuck_i,
  input  wire logic signed [15:0] ph_i,
  // To the synchronizer
  output logic                    aux_o,
  output logic signed [15:0]      slip_o,
  output logic signed [15:0]      phase_o,
  output logic [15:0]             volt_o
);
  logic [1:0] dly_q;
  // A stuck breaker never reports closed; raising stuck again reopens it
  always @(posedge clock_i) begin
    dly_q <= close_i ? dly_q + 2'h1 : 2'h0;
    if (stuck_i) begin
      aux_o <= 1'b0;
    end else if (dly_q == 2'h3) begin
      aux_o <= 1'b1;
    end
  end
  assign slip_o  = spd_bias_i >>> 8;
  assign phase_o = ph_i + (slip_o >>> 2);
  assign volt_o  = 16'(16'sd230 + (volt_bias_i >>> 8));
endmodule // gsm_plant

// ==== verif/gsm_top_bench.sv ====
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the synchronizer mode logic
module gsm_top_bench;
  import gsm_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, seed = 32'd61043;
  logic avs_waitrequest_o, panel_mode_wr_i = 1'b0, auto_sw_i = 1'b0, spd_raise_i = 1'b0;
  logic spd_lower_i = 1'b0, volt_raise_i = 1'b0, volt_lower_i = 1'b0, gen_aux_i;
  logic bus_aux_i = 1'b0, close_o, dead_bus_o, volt_alarm_o, stuck = 1'b1;
  gsm_mode_t panel_mode_i = GSM_OFF, mode_o;
  logic signed [15:0] gen_phase_i, bus_phase_i = 16'sh0, slip_i, spd_bias_o, volt_bias_o;
  logic [15:0] gen_volt_i, bus_volt_i = 16'h0;
  int errors = 0, comparisons = 0, n;
  localparam int CYC = 4;
  logic signed [15:0] ph_off = 16'sh4000;
  always #2.5 clock_i = ~clock_i;
  gsm_top #(.CTRL_CYC(CYC)) dut (.clock_i, .reset_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .panel_mode_wr_i, .panel_mode_i, .auto_sw_i, .spd_raise_i, .spd_lower_i, .volt_raise_i,
    .volt_lower_i, .gen_aux_i, .bus_aux_i, .gen_phase_i, .bus_phase_i, .slip_i, .gen_volt_i,
    .bus_volt_i, .spd_bias_o, .volt_bias_o, .close_o, .dead_bus_o, .volt_alarm_o, .mode_o);
  gsm_plant far (.clock_i(clock_i), .close_i(close_o), .spd_bias_i(spd_bias_o),
    .volt_bias_i(volt_bias_o), .stuck_i(stuck), .ph_i(ph_off), .aux_o(gen_aux_i),
    .slip_o(slip_i), .phase_o(gen_phase_i), .volt_o(gen_volt_i));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_dead(input logic [1:0] r, input logic [15:0] v);
    return v < ((r == 2'h0) ? GSM_DEAD_LO : (r == 2'h1) ? GSM_DEAD_MID : GSM_DEAD_HI);
  endfunction
  // Dead-bus close enabled, voltage matching off
  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [1:0] r);
    return {24'h0, r, 1'b1, 1'b0, 2'h2, m};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Avalon master: hold until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    chk(32'(n < 100), 32'h1, "bus answer");
  endtask
  task automatic ticks(input int t);
    repeat (t * CYC) @(posedge clock_i);
  endtask
  task automatic until_close(input logic v);
    n = 0;
    while (close_o !== v && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(close_o), 32'(v), "close wait");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog, well beyond the longest expected run
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    chk(32'(mode_o), 32'(GSM_OFF), "reset mode");
    chk(32'(close_o), 32'h0, "reset close");
    bus(1'b0, GSM_REG_GAIN, 32'h0);
    chk(q, GSM_GAIN_RST, "gain reset");
    bus(1'b0, GSM_REG_TIME, 32'h0);
    chk(q, GSM_TIME_RST, "time reset");
    bus(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0, "unmapped read");
    spd_raise_i <= 1'b1;
    volt_raise_i <= 1'b1;
    ticks(4);
    chk(32'(spd_bias_o > 0 && volt_bias_o > 0), 32'h1, "manual raise");
    {spd_raise_i, volt_raise_i, spd_lower_i, volt_lower_i} <= 4'h3;
    ticks(8);
    chk(32'(spd_bias_o < 0 && volt_bias_o < 0), 32'h1, "manual lower");
    {spd_lower_i, volt_lower_i} <= 2'h0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, GSM_REG_CTRL, ctrl(2'h0, 2'(i)));
      bus_volt_i <= 16'(xs() % 32'd100);
      ticks(3);
      chk(32'(dead_bus_o), 32'(exp_dead(2'(i), bus_volt_i)), "dead bus");
    end
    bus_volt_i <= 16'h0;
    auto_sw_i <= 1'b1;
    bus(1'b1, GSM_REG_CTRL, ctrl(GSM_CHECK, 2'h0));
    ticks(10);
    chk(32'(mode_o), 32'(GSM_CHECK), "check mode");
    chk(32'(close_o), 32'h0, "check never closes");
    bus(1'b1, GSM_REG_CTRL, ctrl(GSM_RUN, 2'h0));
    until_close(1'b1);
    n = 0;
    while (close_o === 1'b1 && n < 1000) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(n), 32'(int'(GSM_TIME_RST[15:0]) * CYC), "pulse length");
    // Contacts pass the synchroniser before run is commanded again
    bus_aux_i <= 1'b1;
    stuck <= 1'b0;
    ticks(2);
    chk(32'(mode_o), 32'(GSM_OFF), "off after pulse");
    bus(1'b1, GSM_REG_CTRL, ctrl(GSM_RUN, 2'h0));
    ticks(10);
    chk(32'(close_o), 32'h0, "bus breaker closed, phase off");
    chk(32'(mode_o), 32'(GSM_RUN), "run mode");
    bus_aux_i <= 1'b0;
    until_close(1'b1);
    until_close(1'b0);
    ticks(2);
    chk(32'(n < 64 && gen_aux_i), 32'h1, "aux ends pulse");
    chk(32'(mode_o), 32'(GSM_OFF), "off after close");
    stuck <= 1'b1;
    panel_mode_i <= GSM_PERM;
    panel_mode_wr_i <= 1'b1;
    @(posedge clock_i);
    panel_mode_wr_i <= 1'b0;
    ticks(3);
    chk(32'(mode_o), 32'(GSM_PERM), "panel command");
    auto_sw_i <= 1'b0;
    ticks(3);
    chk(32'(mode_o), 32'(GSM_OFF), "auto removed");
    // Permissive, phase type, dead-bus path off: only the phase window can close
    auto_sw_i <= 1'b1;
    bus(1'b1, GSM_REG_CTRL, 32'h0000_0006);
    ticks(10);
    chk(32'(mode_o), 32'(GSM_PERM), "permissive mode");
    chk(32'(close_o), 32'h0, "phase outside window");
    q = 32'(spd_bias_o);
    ph_off <= 16'sh0010;
    until_close(1'b1);
    chk(32'(spd_bias_o), q, "permissive speed bias moved");
    report_and_stop();
  end
endmodule // gsm_top_bench
